// [swhd_pkg.sv]
// Package for the sleep, wake and host detection block.
`default_nettype none
package swhd_pkg;
  localparam int CLK_HZ        = 100_000_000;
  localparam int SLOW_HZ       = 32_000;
  localparam int SLOW_DIV      = CLK_HZ / SLOW_HZ;
  localparam int TMO_W         = 32;
  localparam int NUM_SRC       = 7;
  localparam int SRC_TIMEOUT   = 0;
  localparam int SRC_PIN       = 1;
  localparam int SRC_CMP       = 2;
  localparam int SRC_CAL       = 3;
  localparam int SRC_WDOG      = 4;
  localparam int SRC_HOST      = 5;
  localparam int SRC_GPIO      = 6;
  localparam logic [6:0] SRC_NONE   = 7'h00;
  localparam logic [6:0] DEEP_SRCS  = 7'h1f;
  localparam logic [6:0] LIGHT_SRCS = 7'h61;

  typedef enum logic [2:0] {
    SWHD_IF_NONE = 3'h0,
    SWHD_IF_SDIO = 3'h1,
    SWHD_IF_SPI  = 3'h2,
    SWHD_IF_USB  = 3'h3,
    SWHD_IF_CDC  = 3'h4
  } swhd_if_t;

  typedef enum logic [1:0] {
    SWHD_PWR_ACTIVE = 2'h0,
    SWHD_PWR_DEEP   = 2'h1,
    SWHD_PWR_LIGHT  = 2'h2
  } swhd_pwr_t;

  typedef struct packed {
    logic [6:0]       en;
    logic             pin_pol;
    logic [TMO_W-1:0] tmo;
  } swhd_cfg_t;

  typedef struct packed {
    logic cmp;
    logic cal;
    logic wdog;
    logic pin;
    logic gpio;
    logic host;
  } swhd_evt_t;
endpackage
`default_nettype wire

// [swhd_sync.sv]
// Two-stage synchroniser bank for inputs from outside the clock domain.
`default_nettype none
module swhd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         mclk_in,
  input  wire logic         rstn_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [swhd_slow_timer.sv]
// Slow-tick timeout counter for the always-on domain.
`default_nettype none
module swhd_slow_timer
  import swhd_pkg::*;
#(
  parameter int DIV = SLOW_DIV
) (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             rstn_in,
  // Control
  input  wire logic             run_in,
  input  wire logic [TMO_W-1:0] tmo_in,
  // Status
  output logic                  tick_out,
  output logic                  expire_out
);
  logic [31:0]      div_r;
  logic [TMO_W-1:0] cnt_r;

  // Slow clock is a one-cycle enable, so the always-on logic stays single-clocked.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_r    <= '0;
      tick_out <= 1'b0;
    end else if (div_r == 32'(DIV - 1)) begin
      div_r    <= '0;
      tick_out <= 1'b1;
    end else begin
      div_r    <= div_r + 32'h1;
      tick_out <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r      <= '0;
      expire_out <= 1'b0;
    end else if (!run_in) begin
      cnt_r      <= '0;
      expire_out <= 1'b0;
    end else if (tick_out && !expire_out) begin
      cnt_r      <= cnt_r + 1'b1;
      expire_out <= (cnt_r + 1'b1) >= tmo_in;
    end
  end
endmodule
`default_nettype wire

// [swhd_top.sv]
// Sleep, wake and host interface detection controller.
`default_nettype none
module swhd_top
  import swhd_pkg::*;
#(
  parameter int DIV = SLOW_DIV
) (
  // Clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rstn_in,
  // Firmware control
  input  wire swhd_cfg_t  cfg_in,
  input  wire logic       deep_req_in,
  input  wire logic       light_req_in,
  input  wire logic       pend_clr_in,
  // Wake sources and host activity from pins
  input  wire swhd_evt_t  evt_in,
  input  wire logic       host_done_in,
  // Host detection pins
  input  wire logic       vbus_in,
  input  wire logic       sdio_pkt_ok_in,
  input  wire logic       spi_pkt_ok_in,
  input  wire logic       usb_class_select_pin_in,
  // Status
  output swhd_pwr_t       mode_out,
  output logic            deep_sleep_mode_out,
  output logic            light_sleep_mode_out,
  output logic            deep_refused_out,
  output logic            fast_clk_en_out,
  output logic            subsys_pwr_out,
  output logic            host_busy_out,
  output logic            wake_out,
  output logic [6:0]      wake_pend_out,
  output swhd_if_t        host_if_out,
  output logic            host_if_valid_out,
  output logic            usb_class_select_out
);
  import swhd_pkg::*;

  swhd_evt_t        evt_s;
  logic [2:0]       det_s;
  logic             tick;
  logic             tmo_hit;
  logic             timer_run;
  logic             pin_hit;
  logic [6:0]       hits;
  logic [6:0]       allowed;
  logic [6:0]       fired;
  logic             is_usb;
  swhd_pwr_t        mode_r;
  swhd_pwr_t        mode_nxt;
  swhd_if_t         if_r;
  logic             if_valid_r;
  logic             serving_r;

  swhd_sync #(
    .W ($bits(swhd_evt_t))
  ) u_sync_evt (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .d_in    (evt_in),
    .q_out   (evt_s)
  );

  swhd_sync #(
    .W (3)
  ) u_sync_det (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .d_in    ({vbus_in, sdio_pkt_ok_in, spi_pkt_ok_in}),
    .q_out   (det_s)
  );

  swhd_slow_timer #(
    .DIV (DIV)
  ) u_timer (
    .mclk_in    (mclk_in),
    .rstn_in    (rstn_in),
    .run_in     (timer_run),
    .tmo_in     (cfg_in.tmo),
    .tick_out   (tick),
    .expire_out (tmo_hit)
  );

  assign timer_run = (mode_r != SWHD_PWR_ACTIVE);
  assign pin_hit   = (evt_s.pin == cfg_in.pin_pol);
  assign is_usb    = if_valid_r && ((if_r == SWHD_IF_USB) || (if_r == SWHD_IF_CDC));

  always_comb begin
    hits                = SRC_NONE;
    hits[SRC_TIMEOUT]   = tmo_hit;
    hits[SRC_PIN]       = pin_hit;
    hits[SRC_CMP]       = evt_s.cmp;
    hits[SRC_CAL]       = evt_s.cal;
    hits[SRC_WDOG]      = evt_s.wdog;
    hits[SRC_HOST]      = evt_s.host;
    hits[SRC_GPIO]      = evt_s.gpio;
  end

  // Deep-sleep sources are only sampled on the slow tick, as the always-on domain would.
  always_comb begin
    unique case (mode_r)
      SWHD_PWR_DEEP:  allowed = tick ? DEEP_SRCS : SRC_NONE;
      SWHD_PWR_LIGHT: allowed = LIGHT_SRCS;
      default:        allowed = SRC_NONE;
    endcase
  end

  assign fired = hits & allowed & cfg_in.en;

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      SWHD_PWR_ACTIVE: begin
        if (deep_req_in && !is_usb) begin
          mode_nxt = SWHD_PWR_DEEP;
        end else if (light_req_in) begin
          mode_nxt = SWHD_PWR_LIGHT;
        end
      end
      SWHD_PWR_DEEP: begin
        if (|fired) begin
          mode_nxt = SWHD_PWR_ACTIVE;
        end
      end
      SWHD_PWR_LIGHT: begin
        if (|(fired & ~(7'h1 << SRC_HOST))) begin
          mode_nxt = SWHD_PWR_ACTIVE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_r <= SWHD_PWR_ACTIVE;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // A host command in light sleep is served without leaving the mode.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      serving_r <= 1'b0;
    end else if (mode_r == SWHD_PWR_LIGHT && fired[SRC_HOST]) begin
      serving_r <= 1'b1;
    end else if (host_done_in || mode_r != SWHD_PWR_LIGHT) begin
      serving_r <= 1'b0;
    end
  end

  // Pending flags: a new wake event wins over a clear in the same cycle.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wake_pend_out <= SRC_NONE;
    end else begin
      wake_pend_out <= (pend_clr_in ? SRC_NONE : wake_pend_out) | fired;
    end
  end

  // Detection happens once after power-up; later wakes keep the stored choice, except that USB moves to CDC on class select.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      if_r       <= SWHD_IF_NONE;
      if_valid_r <= 1'b0;
    end else if (!if_valid_r) begin
      if (det_s[2]) begin
        if_r       <= SWHD_IF_USB;
        if_valid_r <= 1'b1;
      end else if (det_s[1]) begin
        if_r       <= SWHD_IF_SDIO;
        if_valid_r <= 1'b1;
      end else if (det_s[0]) begin
        if_r       <= SWHD_IF_SPI;
        if_valid_r <= 1'b1;
      end
    end else if (if_r == SWHD_IF_USB && usb_class_select_out) begin
      if_r <= SWHD_IF_CDC;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_out             <= SWHD_PWR_ACTIVE;
      deep_sleep_mode_out  <= 1'b0;
      light_sleep_mode_out <= 1'b0;
      fast_clk_en_out      <= 1'b1;
      subsys_pwr_out       <= 1'b1;
      host_busy_out        <= 1'b0;
      wake_out             <= 1'b0;
      deep_refused_out     <= 1'b0;
    end else begin
      mode_out             <= mode_nxt;
      deep_sleep_mode_out  <= (mode_nxt == SWHD_PWR_DEEP);
      light_sleep_mode_out <= (mode_nxt == SWHD_PWR_LIGHT);
      fast_clk_en_out      <= (mode_nxt == SWHD_PWR_ACTIVE) || serving_r;
      subsys_pwr_out       <= (mode_nxt != SWHD_PWR_DEEP);
      host_busy_out        <= serving_r;
      wake_out             <= (mode_r != SWHD_PWR_ACTIVE) && (mode_nxt == SWHD_PWR_ACTIVE);
      deep_refused_out     <= (mode_r == SWHD_PWR_ACTIVE) && deep_req_in && is_usb;
    end
  end

  // Class select sampled through the same two-stage path as the other pins.
  logic cls_meta_r;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cls_meta_r           <= 1'b0;
      usb_class_select_out <= 1'b0;
    end else begin
      cls_meta_r           <= usb_class_select_pin_in;
      usb_class_select_out <= cls_meta_r;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      host_if_out       <= SWHD_IF_NONE;
      host_if_valid_out <= 1'b0;
    end else begin
      host_if_out       <= if_r;
      host_if_valid_out <= if_valid_r;
    end
  end
endmodule
`default_nettype wire

// [swhd_checker.sv]
// Port assertions for the sleep, wake and host detection block.
`default_nettype none
module swhd_checker
  import swhd_pkg::*;
(
  // Clock and reset
  input wire logic       mclk_in,
  input wire logic       rstn_in,
  // Watched ports
  input wire logic       deep_req_in,
  input wire logic       pend_clr_in,
  input wire swhd_pwr_t  mode_out,
  input wire logic       deep_sleep_mode_out,
  input wire logic       light_sleep_mode_out,
  input wire logic       deep_refused_out,
  input wire logic       fast_clk_en_out,
  input wire logic       subsys_pwr_out,
  input wire logic       host_busy_out,
  input wire logic       wake_out,
  input wire logic [6:0] wake_pend_out,
  input wire swhd_if_t   host_if_out,
  input wire logic       host_if_valid_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  logic usb_if;
  logic act;
  assign usb_if = host_if_out inside {SWHD_IF_USB, SWHD_IF_CDC};
  assign act = mode_out == SWHD_PWR_ACTIVE;
  deep_off_a: assert property (deep_sleep_mode_out |-> !fast_clk_en_out && !subsys_pwr_out)
    else $error("fast clock or power on in deep sleep");
  usb_refuse_a: assert property (act && deep_req_in && usb_if |=>
    deep_refused_out && !deep_sleep_mode_out) else $error("deep sleep not refused");
  deep_take_a: assert property (act && deep_req_in && host_if_valid_out && !usb_if |=>
    deep_sleep_mode_out) else $error("deep request not taken");
  wake_pulse_a: assert property (wake_out |-> act && wake_pend_out != 7'h00 ##1 !wake_out)
    else $error("bad wake pulse");
  light_gate_a: assert property ((light_sleep_mode_out && !host_busy_out) [*3] |->
    !fast_clk_en_out) else $error("clock running in idle light sleep");
  busy_clk_a: assert property (host_busy_out |-> fast_clk_en_out && light_sleep_mode_out)
    else $error("host served without clock");
  regate_a: assert property ($fell(host_busy_out) |-> ##[0:2] !fast_clk_en_out)
    else $error("clock not gated after host command");
  if_hold_a: assert property (host_if_valid_out |=>
    host_if_out == $past(host_if_out) || host_if_out == SWHD_IF_CDC)
    else $error("host interface changed");
  pend_keep_a: assert property (!pend_clr_in |=>
    (wake_pend_out & $past(wake_pend_out)) == $past(wake_pend_out))
    else $error("pending source lost");
endmodule
bind swhd_top swhd_checker chk (.*);
`default_nettype wire

// [swhd_host_model.sv]
// Host processor model that issues commands and masks its interrupt line.
`default_nettype none
module swhd_host_model #(
  parameter int LAT = 3
) (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rstn_in,
  // Bench and device side
  input  wire logic cmd_in,
  input  wire logic busy_in,
  input  wire logic sleep_in,
  output logic      host_evt_out,
  output logic      host_done_out,
  output logic      irq_mask_out
);
  logic [3:0] cnt_r;
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      host_evt_out <= 1'b0;
      host_done_out <= 1'b0;
      cnt_r <= 4'h0;
    end else begin
      // The command is held until served; no wake sequence is sent first.
      host_evt_out <= cmd_in | (host_evt_out & ~busy_in);
      cnt_r <= busy_in ? cnt_r + 4'h1 : 4'h0;
      host_done_out <= busy_in && cnt_r == 4'(LAT);
    end
  end
  // Masked across all of deep sleep, so a wake glitch never reaches the host.
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) irq_mask_out <= 1'b1;
    else irq_mask_out <= sleep_in;
  end
endmodule
`default_nettype wire

// [swhd_bench.sv]
// Self-checking bench for the sleep, wake and host detection block.
`default_nettype none
module swhd_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import swhd_pkg::*;
  logic mclk_in, rstn_in, deep_req_in, light_req_in, pend_clr_in, host_done_in, cmd, hevt;
  logic vbus_in, sdio_pkt_ok_in, spi_pkt_ok_in, usb_class_select_pin_in, irq_mask;
  logic deep_sleep_mode_out, light_sleep_mode_out, deep_refused_out, fast_clk_en_out;
  logic subsys_pwr_out, host_busy_out, wake_out, host_if_valid_out, usb_class_select_out;
  logic [6:0] wake_pend_out;
  swhd_cfg_t  cfg_in;
  swhd_evt_t  evt, evt_in;
  swhd_pwr_t  mode_out;
  swhd_if_t   host_if_out;
  int         failures, checked;
  swhd_top #(.DIV(4)) uut (.*);
  swhd_host_model host (.mclk_in, .rstn_in, .cmd_in(cmd), .busy_in(host_busy_out),
    .sleep_in(deep_req_in | deep_sleep_mode_out), .host_evt_out(hevt),
    .host_done_out(host_done_in), .irq_mask_out(irq_mask));
  always_comb begin
    evt_in = evt;
    evt_in.host = hevt;
  end
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wait_for(ref logic s, input logic v, input string what);
    int n;
    n = 0;
    while (s !== v && n < 100) begin
      cyc(1);
      n++;
    end
    chk(s, v, what);
  endtask
  task automatic test_done;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic detect(input logic v, s, p, c, input swhd_if_t exp);
    rstn_in = 1'b0;
    vbus_in = v;
    sdio_pkt_ok_in = s;
    spi_pkt_ok_in = p;
    usb_class_select_pin_in = c;
    cyc(2);
    rstn_in = 1'b1;
    cyc(8);
    chk(host_if_out, exp, "host_if");
    chk(host_if_valid_out, 1'b1, "if_valid");
    chk(usb_class_select_out, c, "class_sel");
    if (v) begin
      deep_req_in = 1'b1;
      cyc(1);
      deep_req_in = 1'b0;
      chk(deep_refused_out, 1'b1, "refused");
      chk(mode_out, SWHD_PWR_ACTIVE, "mode");
    end
  endtask
  task automatic wake_test(input int s, input logic lt);
    swhd_pwr_t m;
    m = lt ? SWHD_PWR_LIGHT : SWHD_PWR_DEEP;
    cfg_in.en = (7'h01 << s) | (lt ? 7'h20 : 7'h00);
    cfg_in.tmo = 32'h6;
    deep_req_in = !lt;
    light_req_in = lt;
    cyc(1);
    deep_req_in = 1'b0;
    light_req_in = 1'b0;
    chk(mode_out, m, "mode");
    chk(fast_clk_en_out, 1'b0, "clk_en");
    chk(subsys_pwr_out, lt, "subsys");
    if (!lt) chk(irq_mask, 1'b1, "irq_mask");
    if (lt && s == SRC_GPIO) begin
      cmd = 1'b1;
      cyc(1);
      cmd = 1'b0;
      wait_for(host_busy_out, 1'b1, "busy");
      chk(fast_clk_en_out, 1'b1, "ungated");
      wait_for(fast_clk_en_out, 1'b0, "regated");
      chk(light_sleep_mode_out, 1'b1, "light");
    end
    cyc(8);
    chk(mode_out, m, "held");
    case (s)
      SRC_PIN: evt.pin = 1'b0;
      SRC_CMP: evt.cmp = 1'b1;
      SRC_CAL: evt.cal = 1'b1;
      SRC_WDOG: evt.wdog = 1'b1;
      SRC_GPIO: evt.gpio = 1'b1;
      default: ;
    endcase
    wait_for(wake_out, 1'b1, "wake");
    chk(wake_pend_out[s], 1'b1, "pend");
    chk(host_if_out, SWHD_IF_SDIO, "kept_if");
    evt = '0;
    evt.pin = 1'b1;
    cyc(4);
    pend_clr_in = 1'b1;
    cyc(1);
    pend_clr_in = 1'b0;
    chk(wake_pend_out, 7'h00, "pend_clr");
  endtask
  initial begin
    {rstn_in, deep_req_in, light_req_in, pend_clr_in, cmd, failures, checked} = '0;
    {vbus_in, sdio_pkt_ok_in, spi_pkt_ok_in, usb_class_select_pin_in} = '0;
    cfg_in = '0;
    evt = '0;
    evt.pin = 1'b1;
    detect(1'b1, 1'b0, 1'b0, 1'b0, SWHD_IF_USB);
    detect(1'b0, 1'b0, 1'b1, 1'b0, SWHD_IF_SPI);
    detect(1'b1, 1'b0, 1'b0, 1'b1, SWHD_IF_CDC);
    detect(1'b0, 1'b1, 1'b0, 1'b0, SWHD_IF_SDIO);
    // Late bus activity must not move the stored interface.
    vbus_in = 1'b1;
    spi_pkt_ok_in = 1'b1;
    for (int s = 0; s < 5; s++) wake_test(s, 1'b0);
    wake_test(SRC_TIMEOUT, 1'b1);
    wake_test(SRC_GPIO, 1'b1);
    test_done;
  end
  initial begin
    #100000;
    failures++;
    test_done;
  end
endmodule
`default_nettype wire
